// ==== hdl/port_shadow_config.sv ====
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Group count 1..5 full, 1 lite.
// - Flag 0x0001 makes weighted credits bytes.
// - Flag 0x0002 makes committed credit bytes.
// - Flag 0x0004 congestion thresholds in bytes.
// - Flag 0x0008 throttle threshold in bytes.
// - Flag 0x0010 joins even lite port with odd.
// - Joint pair statistics go through even port.
// - Egress at throttle stops forwarding this iteration.
// - Overhead bytes added before credit charge.
// - Overhead bytes never counted in statistics.
// - Tick grants credit, bytes<<11, packets<<20.
// - Accumulated credit clamped to configured maximum.
// - Dual build: 0x0002 bytes, 0x0020 packets.
// - Dual record: packet credit at 0x10, 0x14.
// - Word 0 flags/groups/queue, word 1 overhead/throttle.
// - Single layout: 0x10 port, 0x18 groups.
// - Dual layout: 0x18 port, 0x28 groups.
// - Full and lite ports share one format.
// - Ports serviced ascending; any egress queue.
// - Group flags 0x20/0x40 select; 0x80 ignored.
module port_shadow_config
    import port_cfg_pkg::*;
#(
    parameter logic DUAL_BUILD = 1'b0,
    parameter logic LITE_PORT  = 1'b0,
    parameter logic ODD_PORT   = 1'b0
)
(
    input  wire logic        REF_CLK,
    input  wire logic        RESET_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output      logic [31:0] WB_DAT_O,
    output      logic        WB_ACK_O,
    input  wire logic        TICK,
    input  wire logic        ITERATION_START,
    input  wire logic        PKT_VALID,
    input  wire logic [31:0] PKT_LENGTH,
    output      logic        PKT_READY,
    input  wire logic [31:0] EGRESS_DEPTH_BYTES,
    input  wire logic [31:0] EGRESS_DEPTH_PKTS,
    input  wire logic [7:0]  GROUP_FLAGS,
    output      logic [15:0] EGRESS_QUEUE,
    output      logic        WEIGHTED_CREDIT_IN_BYTES,
    output      logic        COMMITTED_CREDIT_IN_BYTES,
    output      logic        CONGESTION_IN_BYTES,
    output      logic        THROTTLE_IN_BYTES,
    output      logic        JOINT_PORT_PAIR,
    output      logic        GROUP_BY_BYTES,
    output      logic        GROUP_BY_PACKETS,
    output      logic        STATS_VIA_THIS_PORT,
    output      logic [31:0] STAT_BYTES,
    output      logic        PORT_ACTIVE
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] word0;
        logic [31:0] word1;
        logic [31:0] credit;
        logic [31:0] credit_max;
        logic [31:0] pkt_credit;
        logic [31:0] pkt_credit_max;
        logic        enable;
        logic        throttled;
        logic        ack;
        logic [31:0] rdata;
        logic [6:0]  locate;
        logic [31:0] stat_bytes;
    } cfg_state_t;

    cfg_state_t state_r;
    cfg_state_t state_nxt;

    logic [7:0]  unit_flags;
    logic [7:0]  group_count;
    logic [7:0]  overhead;
    logic [15:0] throttle;
    logic        group_count_ok;
    logic        byte_sched;
    logic        pkt_sched;
    logic        wb_hit;
    logic        forward;
    logic [31:0] charge_len;
    logic [31:0] byte_grant;
    logic [31:0] byte_cap;
    logic [31:0] pkt_grant;
    logic [31:0] pkt_cap;
    logic [31:0] byte_level;
    logic [31:0] pkt_level;
    logic [32:0] throttle_depth;
    logic        throttle_hit;
    logic [9:0]  shadow_offset;
    logic [31:0] wmask;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    assign unit_flags  = state_r.word0[7:0];
    assign group_count = state_r.word0[15:8];
    assign overhead    = state_r.word1[7:0];
    assign throttle    = state_r.word1[31:16];

    // The same check serves full and lite ports; only the ceiling differs.
    assign group_count_ok = (group_count >= GROUPS_MIN) &&
                            (group_count <= (LITE_PORT ? GROUPS_LITE : GROUPS_MAX_FULL));

    // In the single build one flag picks the unit; in the dual build two
    // flags enable independent buckets, possibly both.
    assign byte_sched = unit_flags[FLAG_COMMITTED_BYTES];
    assign pkt_sched  = DUAL_BUILD ? unit_flags[FLAG_SCHED_PACKETS]
                                   : !unit_flags[FLAG_COMMITTED_BYTES];

    // Registered credit fields are already in scaled units.
    assign byte_grant = state_r.credit;
    assign byte_cap   = state_r.credit_max;
    assign pkt_grant  = DUAL_BUILD ? state_r.pkt_credit : state_r.credit;
    assign pkt_cap    = DUAL_BUILD ? state_r.pkt_credit_max : state_r.credit_max;

    // Overhead is charged against credit only; statistics see the raw length.
    assign charge_len = 32'(({PKT_LENGTH} + 32'(overhead)) << BYTE_CREDIT_SHIFT);

    assign throttle_depth = {1'b0, unit_flags[FLAG_THROTTLE_BYTES] ? EGRESS_DEPTH_BYTES
                                                                   : EGRESS_DEPTH_PKTS};

    // Ready also watches the live depth, so the packet that fills the queue is the last one.
    assign throttle_hit = (throttle != 16'h0000) &&
                          (throttle_depth >= {17'h0_0000, throttle});

    // A joined odd port must stay off; its queues are scheduled by the even port.
    assign PORT_ACTIVE = state_r.enable && group_count_ok &&
                         !(ODD_PORT && unit_flags[FLAG_JOINT_PAIR]);

    assign PKT_READY = PORT_ACTIVE && !state_r.throttled && !throttle_hit &&
                       (!byte_sched || byte_level >= charge_len) &&
                       (!pkt_sched || pkt_level >= (32'h1 << PKT_CREDIT_SHIFT));
    assign forward   = PKT_VALID && PKT_READY;

    assign wb_hit = WB_CYC_I && WB_STB_I && !state_r.ack;

    generate
        for (genvar b = 0; b < 4; b++)
        begin : g_mask
            assign wmask[8*b +: 8] = {8{WB_SEL_I[b]}};
        end
    endgenerate

    // ------------------------------------------------------------------
    // Credit buckets
    // ------------------------------------------------------------------
    credit_bucket u_byte_bucket (
        .clk           (REF_CLK),
        .rst_n         (RESET_N),
        .enable        (PORT_ACTIVE && byte_sched),
        .tick          (TICK),
        .credit        (byte_grant),
        .credit_max    (byte_cap),
        .charge        (forward),
        .charge_amount (charge_len),
        .level         (byte_level)
    );

    credit_bucket u_pkt_bucket (
        .clk           (REF_CLK),
        .rst_n         (RESET_N),
        .enable        (PORT_ACTIVE && pkt_sched),
        .tick          (TICK),
        .credit        (pkt_grant),
        .credit_max    (pkt_cap),
        .charge        (forward),
        .charge_amount (32'h1 << PKT_CREDIT_SHIFT),
        .level         (pkt_level)
    );

    shadow_locator u_locator (
        .dual_build (DUAL_BUILD),
        .group_idx  (state_r.locate[6:4]),
        .queue_idx  (state_r.locate[3:0]),
        .offset     (shadow_offset)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_nxt       = state_r;
        state_nxt.ack   = wb_hit;
        state_nxt.rdata = WORD_RESET;

        // Throttle latches in any cycle the live depth reaches it and is released only at iteration start, which wins.
        if (ITERATION_START)
        begin
            state_nxt.throttled = 1'b0;
        end
        else if (throttle_hit)
        begin
            state_nxt.throttled = 1'b1;
        end

        if (forward)
        begin
            state_nxt.stat_bytes = state_r.stat_bytes + PKT_LENGTH;
        end

        if (wb_hit && WB_WE_I)
        begin
            case (WB_ADR_I)
                OFS_EGRESS_GROUPS_FLAGS:
                    state_nxt.word0 = (state_r.word0 & ~wmask) | (WB_DAT_I & wmask);
                OFS_THROTTLE_OVERHEAD:
                    // Byte 1 is reserved and never stored.
                    state_nxt.word1 = ((state_r.word1 & ~wmask) | (WB_DAT_I & wmask))
                                      & 32'hffff_00ff;
                OFS_COMMITTED_CREDIT:
                    state_nxt.credit = (state_r.credit & ~wmask) | (WB_DAT_I & wmask);
                OFS_COMMITTED_CREDIT_MAX:
                    state_nxt.credit_max = (state_r.credit_max & ~wmask) | (WB_DAT_I & wmask);
                OFS_COMMITTED_PKT_CREDIT:
                    if (DUAL_BUILD)
                    begin
                        state_nxt.pkt_credit = (state_r.pkt_credit & ~wmask)
                                               | (WB_DAT_I & wmask);
                    end
                OFS_COMMITTED_PKT_CREDIT_MAX:
                    if (DUAL_BUILD)
                    begin
                        state_nxt.pkt_credit_max = (state_r.pkt_credit_max & ~wmask)
                                                   | (WB_DAT_I & wmask);
                    end
                OFS_CONTROL:
                    if (WB_SEL_I[0])
                    begin
                        state_nxt.enable = WB_DAT_I[0];
                    end
                OFS_SHADOW_INDEX:
                    if (WB_SEL_I[0])
                    begin
                        state_nxt.locate = WB_DAT_I[6:0];
                    end
                default:
                    state_nxt.word0 = state_r.word0;
            endcase
        end
        else if (wb_hit)
        begin
            case (WB_ADR_I)
                OFS_EGRESS_GROUPS_FLAGS:  state_nxt.rdata = state_r.word0;
                OFS_THROTTLE_OVERHEAD:    state_nxt.rdata = state_r.word1;
                OFS_COMMITTED_CREDIT:     state_nxt.rdata = state_r.credit;
                OFS_COMMITTED_CREDIT_MAX: state_nxt.rdata = state_r.credit_max;
                OFS_COMMITTED_PKT_CREDIT:
                    state_nxt.rdata = DUAL_BUILD ? state_r.pkt_credit : WORD_RESET;
                OFS_COMMITTED_PKT_CREDIT_MAX:
                    state_nxt.rdata = DUAL_BUILD ? state_r.pkt_credit_max : WORD_RESET;
                OFS_CONTROL:              state_nxt.rdata = {31'h0, state_r.enable};
                OFS_STATUS:
                    state_nxt.rdata = {26'h0, group_count_ok, PKT_READY,
                                       state_r.throttled, pkt_sched, byte_sched, PORT_ACTIVE};
                OFS_BYTE_ACCUM:           state_nxt.rdata = byte_level;
                OFS_PKT_ACCUM:            state_nxt.rdata = pkt_level;
                OFS_SHADOW_INDEX:         state_nxt.rdata = {25'h0, state_r.locate};
                OFS_SHADOW_OFFSET:        state_nxt.rdata = {22'h0, shadow_offset};
                default:                  state_nxt.rdata = WORD_RESET;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The egress queue is passed through unchecked; any managed queue is
    // legal, and ascending port chaining is left to software.
    assign EGRESS_QUEUE              = state_r.word0[31:16];
    assign WEIGHTED_CREDIT_IN_BYTES  = unit_flags[FLAG_WEIGHTED_BYTES];
    assign COMMITTED_CREDIT_IN_BYTES = unit_flags[FLAG_COMMITTED_BYTES];
    assign CONGESTION_IN_BYTES       = unit_flags[FLAG_CONGESTION_BYTES];
    assign THROTTLE_IN_BYTES         = unit_flags[FLAG_THROTTLE_BYTES];
    assign JOINT_PORT_PAIR           = unit_flags[FLAG_JOINT_PAIR];
    assign STATS_VIA_THIS_PORT       = !(ODD_PORT && unit_flags[FLAG_JOINT_PAIR]);
    // Bit 0x80 of the group flags is deliberately left unread.
    assign GROUP_BY_BYTES   = DUAL_BUILD ? GROUP_FLAGS[GFLAG_BY_BYTES] : byte_sched;
    assign GROUP_BY_PACKETS = DUAL_BUILD ? GROUP_FLAGS[GFLAG_BY_PACKETS] : pkt_sched;
    assign STAT_BYTES = state_r.stat_bytes;
    assign WB_ACK_O   = state_r.ack;
    assign WB_DAT_O   = state_r.rdata;

endmodule // port_shadow_config

// ==== hdl/port_cfg_pkg.sv ====
package port_cfg_pkg;

    // --------------------
    // Register map (byte addresses, one aligned word each)
    // --------------------
    localparam logic [7:0] OFS_EGRESS_GROUPS_FLAGS   = 8'h00;
    localparam logic [7:0] OFS_THROTTLE_OVERHEAD     = 8'h04;
    localparam logic [7:0] OFS_COMMITTED_CREDIT      = 8'h08;
    localparam logic [7:0] OFS_COMMITTED_CREDIT_MAX  = 8'h0c;
    localparam logic [7:0] OFS_COMMITTED_PKT_CREDIT  = 8'h10;
    localparam logic [7:0] OFS_COMMITTED_PKT_CREDIT_MAX = 8'h14;
    localparam logic [7:0] OFS_CONTROL               = 8'h18;
    localparam logic [7:0] OFS_STATUS                = 8'h1c;
    localparam logic [7:0] OFS_BYTE_ACCUM            = 8'h20;
    localparam logic [7:0] OFS_PKT_ACCUM             = 8'h24;
    localparam logic [7:0] OFS_SHADOW_INDEX          = 8'h28;
    localparam logic [7:0] OFS_SHADOW_OFFSET         = 8'h2c;

    // --------------------
    // Unit flag bits (byte 0 of word 0)
    // --------------------
    localparam int unsigned FLAG_WEIGHTED_BYTES  = 0;
    localparam int unsigned FLAG_COMMITTED_BYTES = 1;
    localparam int unsigned FLAG_CONGESTION_BYTES = 2;
    localparam int unsigned FLAG_THROTTLE_BYTES  = 3;
    localparam int unsigned FLAG_JOINT_PAIR      = 4;
    localparam int unsigned FLAG_SCHED_PACKETS   = 5;

    // Group flag bits of the dual-unit group record.
    localparam int unsigned GFLAG_BY_BYTES   = 5;
    localparam int unsigned GFLAG_BY_PACKETS = 6;

    // --------------------
    // Credit scaling and group count limits
    // --------------------
    localparam int unsigned BYTE_CREDIT_SHIFT = 11;
    localparam int unsigned PKT_CREDIT_SHIFT  = 20;
    localparam logic [7:0]  GROUPS_MIN      = 8'h01;
    localparam logic [7:0]  GROUPS_MAX_FULL = 8'h05;
    localparam logic [7:0]  GROUPS_LITE     = 8'h01;
    localparam int unsigned QUEUES_PER_GROUP = 8;

    // --------------------
    // Shadow layout of one port, both builds
    // --------------------
    localparam logic [9:0] SINGLE_PORT_SIZE  = 10'h010;
    localparam logic [9:0] SINGLE_GROUP_SIZE = 10'h018;
    localparam logic [9:0] DUAL_PORT_SIZE    = 10'h018;
    localparam logic [9:0] DUAL_GROUP_SIZE   = 10'h028;
    localparam logic [9:0] QUEUE_REC_SIZE    = 10'h008;

    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // --------------------
    // Carriers
    // --------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] length;
    } pkt_t;

endpackage

// ==== hdl/credit_bucket.sv ====
`timescale 1ns/1ps
module credit_bucket
    import port_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        enable,
    input  wire logic        tick,
    input  wire logic [31:0] credit,
    input  wire logic [31:0] credit_max,
    input  wire logic        charge,
    input  wire logic [31:0] charge_amount,
    output      logic [31:0] level
);

    typedef struct packed {
        logic [31:0] level;
    } bucket_state_t;

    bucket_state_t state_r;
    bucket_state_t state_nxt;
    logic [32:0]   sum;

    always_comb
    begin
        state_nxt = state_r;
        sum       = {1'b0, state_r.level};
        if (!enable)
        begin
            sum = 33'h0_0000_0000;
        end
        else
        begin
            if (tick)
            begin
                sum = sum + {1'b0, credit};
            end
            // Clamping after the grant keeps a long idle spell from banking credit.
            if (sum > {1'b0, credit_max})
            begin
                sum = {1'b0, credit_max};
            end
            if (charge)
            begin
                sum = (sum > {1'b0, charge_amount}) ? sum - {1'b0, charge_amount}
                                                    : 33'h0_0000_0000;
            end
        end
        state_nxt.level = sum[31:0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign level = state_r.level;

endmodule // credit_bucket

// ==== hdl/shadow_locator.sv ====
`timescale 1ns/1ps
module shadow_locator
    import port_cfg_pkg::*;
(
    input  wire logic       dual_build,
    input  wire logic [2:0] group_idx,
    input  wire logic [3:0] queue_idx,
    output      logic [9:0] offset
);

    logic [9:0] port_size;
    logic [9:0] group_size;
    logic [9:0] stride;

    // Each group is its record plus eight queue records; a queue index of
    // eight or more selects the group record itself.
    always_comb
    begin
        port_size  = dual_build ? DUAL_PORT_SIZE : SINGLE_PORT_SIZE;
        group_size = dual_build ? DUAL_GROUP_SIZE : SINGLE_GROUP_SIZE;
        stride     = group_size + 10'(QUEUES_PER_GROUP) * QUEUE_REC_SIZE;
        offset     = port_size + 10'(group_idx) * stride;
        if (!queue_idx[3])
        begin
            offset = offset + group_size + 10'(queue_idx[2:0]) * QUEUE_REC_SIZE;
        end
    end

endmodule // shadow_locator

// ==== testbench/port_cfg_chk.sv ====
`timescale 1ns/1ps
module port_cfg_chk
    import port_cfg_pkg::*;
#(
    parameter logic DUAL_BUILD = 1'b0,
    parameter logic ODD_PORT   = 1'b0
)
(
    input logic        REF_CLK,
    input logic        RESET_N,
    input logic        WB_CYC_I,
    input logic        WB_STB_I,
    input logic        WB_WE_I,
    input logic [7:0]  WB_ADR_I,
    input logic [3:0]  WB_SEL_I,
    input logic [31:0] WB_DAT_I,
    input logic        WB_ACK_O,
    input logic        PKT_VALID,
    input logic [31:0] PKT_LENGTH,
    input logic        PKT_READY,
    input logic [7:0]  GROUP_FLAGS,
    input logic [15:0] EGRESS_QUEUE,
    input logic        WEIGHTED_CREDIT_IN_BYTES,
    input logic        THROTTLE_IN_BYTES,
    input logic        JOINT_PORT_PAIR,
    input logic        GROUP_BY_BYTES,
    input logic        GROUP_BY_PACKETS,
    input logic        STATS_VIA_THIS_PORT,
    input logic [31:0] STAT_BYTES,
    input logic        PORT_ACTIVE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    wire logic w0_wr = WB_ACK_O && WB_WE_I && (WB_ADR_I == OFS_EGRESS_GROUPS_FLAGS);

    ack_answers_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("stray ack");
    flag_word_a: assert property (w0_wr && WB_SEL_I[0] |=>
        WEIGHTED_CREDIT_IN_BYTES == $past(WB_DAT_I[0]) && THROTTLE_IN_BYTES == $past(WB_DAT_I[3])
        && JOINT_PORT_PAIR == $past(WB_DAT_I[4])) else $error("flag byte wrong");
    egress_word_a: assert property (w0_wr && WB_SEL_I[3:2] == 2'b11 |=>
        EGRESS_QUEUE == $past(WB_DAT_I[31:16])) else $error("egress queue wrong");
    stat_fwd_a: assert property (PKT_VALID && PKT_READY |=>
        STAT_BYTES == $past(STAT_BYTES) + $past(PKT_LENGTH)) else $error("statistics off");
    stat_hold_a: assert property (!(PKT_VALID && PKT_READY) |=> $stable(STAT_BYTES))
        else $error("statistics moved");
    idle_port_a: assert property (!PORT_ACTIVE |-> !PKT_READY)
        else $error("idle port ready");
    group_sel_a: assert property (DUAL_BUILD |-> GROUP_BY_BYTES == GROUP_FLAGS[5]
        && GROUP_BY_PACKETS == GROUP_FLAGS[6]) else $error("group select wrong");
    stats_route_a: assert property (STATS_VIA_THIS_PORT == !(JOINT_PORT_PAIR && ODD_PORT))
        else $error("statistics route wrong");

    cover property (PKT_VALID && PKT_READY);
    cover property (w0_wr);
    cover property (GROUP_BY_BYTES && GROUP_BY_PACKETS);
endmodule // port_cfg_chk

bind port_shadow_config port_cfg_chk #(.DUAL_BUILD(DUAL_BUILD), .ODD_PORT(ODD_PORT)) chk (.*);

// ==== testbench/egress_queue_model.sv ====
`timescale 1ns/1ps
module egress_queue_model
    import port_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        offer,
    input  wire logic [31:0] offer_len,
    input  wire logic        drain,
    input  wire logic        ready,
    output      pkt_t        pkt,
    output      logic [31:0] depth_bytes,
    output      logic [31:0] depth_pkts
);
    // Idle length lines toggle so a stale length can never look valid.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pkt         <= '0;
            depth_bytes <= '0;
            depth_pkts  <= '0;
        end
        else
        begin
            if (pkt.valid && ready)
            begin
                depth_bytes <= depth_bytes + pkt.length;
                depth_pkts  <= depth_pkts + 32'h1;
            end
            if (drain)
            begin
                depth_bytes <= '0;
                depth_pkts  <= '0;
            end
            if (!pkt.valid || ready)
            begin
                pkt.valid  <= offer;
                pkt.length <= offer ? offer_len : ~pkt.length;
            end
        end
    end
endmodule // egress_queue_model

// ==== testbench/qos_port_shadow_config_test.sv ====
`timescale 1ns/1ps
module qos_port_shadow_config_test
    import port_cfg_pkg::*;
;
    typedef struct packed {logic [7:0] adr; logic [31:0] wdat; logic [31:0] exp;} row_t;
    logic ref_clk = 1'b0, reset_n = 1'b0, tick, iter_start, offer, drain, ready, active;
    logic wb, cb, gb, tb, jp, g_b, g_p, via;
    logic [7:0]  group_flags;
    logic [15:0] egress_queue;
    logic [31:0] offer_len, dep_b, dep_p, stat_bytes, rdat;
    wb_req_t req;
    wb_rsp_t rsp;
    pkt_t    pkt;
    int      errors = 0, comparisons = 0, i;
    row_t rows [7] = '{'{8'h00, 32'h1234_0123, 32'h1234_0123},
        '{8'h04, 32'h0002_ff18, 32'h0002_0018},
        '{8'h08, 32'h0010_0000, 32'h0010_0000}, '{8'h0c, 32'h0018_0000, 32'h0018_0000},
        '{8'h10, 32'h0030_0000, 32'h0030_0000}, '{8'h14, 32'h0040_0000, 32'h0040_0000},
        '{8'h3c, 32'hdead_beef, 32'h0000_0000}};
    logic [7:0] idx [5] = '{8'h08, 8'h00, 8'h18, 8'h28, 8'h47};
    logic [31:0] ofs [5] = '{32'h018, 32'h040, 32'h080, 32'h0e8, 32'h218};
    logic [7:0] cnts [4] = '{8'h00, 8'h06, 8'h05, 8'h01};

    port_shadow_config #(.DUAL_BUILD(1'b1), .LITE_PORT(1'b0), .ODD_PORT(1'b0)) DUT (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .WB_CYC_I(req.cyc), .WB_STB_I(req.stb),
        .WB_WE_I(req.we), .WB_ADR_I(req.adr), .WB_SEL_I(req.sel), .WB_DAT_I(req.dat),
        .WB_DAT_O(rsp.dat), .WB_ACK_O(rsp.ack), .TICK(tick), .ITERATION_START(iter_start),
        .PKT_VALID(pkt.valid), .PKT_LENGTH(pkt.length), .PKT_READY(ready),
        .EGRESS_DEPTH_BYTES(dep_b), .EGRESS_DEPTH_PKTS(dep_p), .GROUP_FLAGS(group_flags),
        .EGRESS_QUEUE(egress_queue), .WEIGHTED_CREDIT_IN_BYTES(wb), .COMMITTED_CREDIT_IN_BYTES(cb),
        .CONGESTION_IN_BYTES(gb), .THROTTLE_IN_BYTES(tb), .JOINT_PORT_PAIR(jp),
        .GROUP_BY_BYTES(g_b), .GROUP_BY_PACKETS(g_p), .STATS_VIA_THIS_PORT(via),
        .STAT_BYTES(stat_bytes), .PORT_ACTIVE(active));
    egress_queue_model partner (.clk(ref_clk), .rst_n(reset_n), .offer(offer),
        .offer_len(offer_len), .drain(drain), .ready(ready), .pkt(pkt),
        .depth_bytes(dep_b), .depth_pkts(dep_p));

    always #20 ref_clk = ~ref_clk;

    // --------------------
    // Checking and bus tasks
    // --------------------
    task wrap_up;
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                  input logic [31:0] wdat, output logic [31:0] data);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, we, adr, sel, wdat};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (rsp.ack !== 1'b1 && n < 20);
        check({31'h0, rsp.ack}, 32'h1);
        if (rsp.ack !== 1'b1)
            wrap_up();
        data = rsp.dat;
        req <= '0;
        @(posedge ref_clk);
    endtask
    task rd(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 4'hf, 32'h0, rdat);
        check(rdat, exp);
    endtask
    task wait_stat(input logic [31:0] exp);
        int n;
        n = 0;
        while (stat_bytes !== exp && n < 60)
        begin
            @(posedge ref_clk);
            n++;
        end
        check(stat_bytes, exp);
        if (stat_bytes !== exp)
            wrap_up();
    endtask

    // --------------------
    // Main sequence
    // --------------------
    initial
    begin
        {req, tick, iter_start, offer, drain, group_flags, offer_len} = '0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        check({31'h0, ready}, 32'h0);
        for (i = 0; i < 7; i++)
        begin
            rd(rows[i].adr, 32'h0);
            wb_cycle(1'b1, rows[i].adr, 4'hf, rows[i].wdat, rdat);
            rd(rows[i].adr, rows[i].exp);
        end
        check({16'h0, egress_queue}, 32'h1234);
        for (i = 0; i < 5; i++)
        begin
            wb_cycle(1'b1, OFS_EGRESS_GROUPS_FLAGS, 4'h1, 32'h1 << i, rdat);
            check({27'h0, jp, tb, gb, cb, wb}, 32'h1 << i);
            check({31'h0, via}, 32'h1);
        end
        wb_cycle(1'b1, OFS_EGRESS_GROUPS_FLAGS, 4'h1, 32'h23, rdat);
        wb_cycle(1'b1, OFS_CONTROL, 4'hf, 32'h1, rdat);
        for (i = 0; i < 4; i++)
        begin
            wb_cycle(1'b1, OFS_EGRESS_GROUPS_FLAGS, 4'h2, {16'hffff, cnts[i], 8'hff}, rdat);
            rd(OFS_EGRESS_GROUPS_FLAGS, {16'h1234, cnts[i], 8'h23});
            check({31'h0, active}, {31'h0, cnts[i] != 8'h0 && cnts[i] < 8'h6});
        end
        for (i = 0; i < 5; i++)
        begin
            wb_cycle(1'b1, OFS_SHADOW_INDEX, 4'hf, {24'h0, idx[i]}, rdat);
            rd(OFS_SHADOW_OFFSET, ofs[i]);
        end
        for (i = 0; i < 4; i++)
        begin
            group_flags <= 8'h20 << i;
            @(posedge ref_clk);
            check({30'h0, g_p, g_b}, {30'h0, group_flags[6:5]});
        end
        for (i = 1; i < 3; i++)
        begin
            tick <= 1'b1;
            @(posedge ref_clk);
            tick <= 1'b0;
            @(posedge ref_clk);
            rd(OFS_BYTE_ACCUM, (i == 1) ? 32'h0010_0000 : 32'h0018_0000);
            rd(OFS_PKT_ACCUM, (i == 1) ? 32'h0030_0000 : 32'h0040_0000);
        end
        offer_len <= 32'h64;
        offer <= 1'b1;
        @(posedge ref_clk);
        offer <= 1'b0;
        wait_stat(32'd100);
        rd(OFS_BYTE_ACCUM, 32'h0014_2000);
        rd(OFS_PKT_ACCUM, 32'h0030_0000);
        offer <= 1'b1;
        wait_stat(32'd200);
        repeat (6) @(posedge ref_clk);
        check(stat_bytes, 32'd200);
        drain <= 1'b1;
        iter_start <= 1'b1;
        @(posedge ref_clk);
        {drain, iter_start} <= 2'b00;
        wait_stat(32'd300);
        offer <= 1'b0;
        reset_n <= 1'b0;
        @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        check(stat_bytes, 32'h0);
        rd(OFS_EGRESS_GROUPS_FLAGS, 32'h0);
        wrap_up();
    end
endmodule // qos_port_shadow_config_test
